// file: bsr_status_unit.sv
// Purpose: Status byte, event structures, service request, error queue
// Assumes: Condition inputs and commands come from logic on CORE_CLK
// Notes: One command per cycle, answer one cycle later
//        A new condition edge wins over a read or clear of its event
//        A full error queue drops new entries unless popped that cycle
//        Transition senses are fixed by constants, not by commands
//
// Functional notes
// RULE_01 - Bits 0-5,7 are one-bit summaries
// RULE_02 - Master summary is status AND enable nonzero
// RULE_03 - Status query bit 6 carries master summary
// RULE_04 - Poll bit 6 is request flag, poll clears
// RULE_05 - Bit 4 set while output queue holds data
// RULE_06 - Bit 5 is standard event summary
// RULE_07 - Bit 7 set while error queue nonempty
// RULE_08 - Bits 1-3 instrument, coupling, hardware; 0 zero
// RULE_09 - Service enable writable and readable by controller
// RULE_10 - Condition reads are live, never writable
// RULE_11 - Transition sense fixed at build time
// RULE_12 - Event bits latch until read or clear
// RULE_13 - Re-set only on fresh transition
// RULE_14 - Enable registers read/write; summary is AND nonzero
// RULE_15 - Enables survive clear, zero at power-on
// RULE_16 - Hardware bits 0-7 trip, unlock, reference, mod levels
// RULE_17 - Hardware bits 14,15 used; 8-13 read zero
// RULE_18 - Instrument bits 0-3 activities; 4-7 unused
// RULE_19 - Error query gives head, 0 empty, 255 full
// RULE_20 - Service enable bit 6 ignores writes, reads zero
// RULE_21 - Request flag sets on new reason, clears
// RULE_22 - Status byte query clears nothing
// RULE_23 - Events to status byte within one cycle
`timescale 1ns/100ps
`include "bsr_defines.svh"

module bsr_status_unit #(
    parameter int COUPL_W = 16,
    parameter int ERRQ_DEPTH = `BSR_ERRQ_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CMD_VALID,
    input wire logic [4:0] CMD_CODE,
    input wire logic [15:0] CMD_DATA,
    output logic RESP_VALID,
    output logic [15:0] RESP_DATA,
    input wire logic POLL_STROBE,
    output logic POLL_VALID,
    output logic [7:0] POLL_DATA,
    output logic SRQ,
    output logic [7:0] STATUS_BYTE,
    input wire logic OUTQ_NOT_EMPTY,
    input wire logic [7:0] STD_EVENT_SET,
    input wire logic [15:0] HW_COND,
    input wire logic [COUPL_W-1:0] COUPL_COND,
    input wire logic [7:0] INSTR_COND,
    input wire logic ERR_PUSH,
    input wire logic [7:0] ERR_CODE,
    output logic ERR_QUEUE_FULL
);
    // Pointer width of the error queue
    localparam int PW = $clog2(ERRQ_DEPTH);

    // Refuse sizes the pointers or the coupling view cannot serve
    if (COUPL_W < 1 || COUPL_W > 16 || ERRQ_DEPTH < 2 || ERRQ_DEPTH > 256
        || (1 << PW) != ERRQ_DEPTH) begin : g_bad_params
        $error("bsr_status_unit: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed transition filter: selected edge of each condition bit
    function automatic logic [15:0] trans_f(input logic [15:0] cur, input logic [15:0] prv,
                                            input logic [15:0] rise);
        trans_f = (rise & cur & ~prv) | (~rise & ~cur & prv); // RULE_11 RULE_13
    endfunction

    // Command decode helper
    function automatic logic is_cmd(input logic v, input logic [4:0] code,
                                    input bsr_pkg::bsr_cmd_t c);
        is_cmd = v && (code == c);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Condition views and their previous samples
    logic armed_q;
    logic [15:0] hw_live;
    logic [15:0] coupl_live;
    logic [7:0] instr_live;
    logic [15:0] hw_prev_q;
    logic [15:0] coupl_prev_q;
    logic [7:0] instr_prev_q;
    // Latched events and their enables
    logic [15:0] hw_ev_q, coupl_ev_q, hw_en_q, coupl_en_q;
    logic [7:0] instr_ev_q, instr_en_q, std_ev_q, std_en_q, sre_q;
    // Transition filter outputs
    logic [15:0] hw_set;
    logic [15:0] coupl_set;
    logic [7:0] instr_set;
    // Summary bits and service request
    logic do_cls;
    logic hsb, csb, ssb, esb, erb, mss;
    logic [7:0] sb_core;
    logic [7:0] reason;
    logic [7:0] reason_prev_q;
    logic rqs_q;
    // Error queue storage and pointers
    logic [7:0] errq_mem [ERRQ_DEPTH];
    logic [PW-1:0] rd_ptr_q;
    logic [PW-1:0] wr_ptr_q;
    logic [PW:0] err_cnt_q;
    logic err_pop, err_push_ok, err_full;

    // Live condition views, unused bits forced low
    assign hw_live = HW_COND & `BSR_HW_USED; // RULE_16 RULE_17 RULE_10
    assign instr_live = INSTR_COND & `BSR_INSTR_USED; // RULE_18 RULE_10
    assign coupl_live = 16'(COUPL_COND);
    assign do_cls = is_cmd(CMD_VALID, CMD_CODE, bsr_pkg::BSR_CMD_CLEAR_STATUS);

    // Filter outputs, quiet until first sample after reset
    assign hw_set = armed_q ? trans_f(hw_live, hw_prev_q, `BSR_HW_RISE) : 16'h0000;
    assign coupl_set = armed_q ? trans_f(coupl_live, coupl_prev_q, `BSR_COUPL_RISE)
                               : 16'h0000;
    assign instr_set = armed_q ? 8'(trans_f({8'h00, instr_live}, {8'h00, instr_prev_q},
                                            {8'h00, `BSR_INSTR_RISE}))
                               : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Previous condition samples
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            armed_q <= 1'b0;
            hw_prev_q <= `BSR_RST16;
            coupl_prev_q <= `BSR_RST16;
            instr_prev_q <= `BSR_RST8;
        end else begin
            armed_q <= 1'b1;
            hw_prev_q <= hw_live;
            coupl_prev_q <= coupl_live;
            instr_prev_q <= instr_live;
        end
    end

    // Latched event registers; a new edge wins over read or clear
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hw_ev_q <= `BSR_RST16;
            coupl_ev_q <= `BSR_RST16;
            instr_ev_q <= `BSR_RST8;
            std_ev_q <= `BSR_RST8;
        end else begin
            hw_ev_q <= (do_cls || is_cmd(CMD_VALID, CMD_CODE, bsr_pkg::BSR_CMD_HW_EVENT_Q)
                        ? 16'h0000 : hw_ev_q) | hw_set; // RULE_12
            coupl_ev_q <= (do_cls || is_cmd(CMD_VALID, CMD_CODE,
                           bsr_pkg::BSR_CMD_COUPL_EVENT_Q) ? 16'h0000 : coupl_ev_q)
                          | coupl_set; // RULE_12
            instr_ev_q <= (do_cls || is_cmd(CMD_VALID, CMD_CODE,
                           bsr_pkg::BSR_CMD_INSTR_EVENT_Q) ? 8'h00 : instr_ev_q)
                          | instr_set; // RULE_12
            std_ev_q <= (do_cls || is_cmd(CMD_VALID, CMD_CODE, bsr_pkg::BSR_CMD_STD_EVENT_Q)
                         ? 8'h00 : std_ev_q) | STD_EVENT_SET; // RULE_12
        end
    end

    // Enable registers, untouched by clear
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hw_en_q <= `BSR_RST16; // RULE_15
            coupl_en_q <= `BSR_RST16;
            instr_en_q <= `BSR_RST8;
            std_en_q <= `BSR_RST8;
            sre_q <= `BSR_RST8;
        end else if (CMD_VALID) begin
            unique case (CMD_CODE)
                bsr_pkg::BSR_CMD_HW_ENABLE_W: hw_en_q <= CMD_DATA; // RULE_14
                bsr_pkg::BSR_CMD_COUPL_ENABLE_W: coupl_en_q <= CMD_DATA;
                bsr_pkg::BSR_CMD_INSTR_ENABLE_W: instr_en_q <= CMD_DATA[7:0];
                bsr_pkg::BSR_CMD_STD_ENABLE_W: std_en_q <= CMD_DATA[7:0];
                bsr_pkg::BSR_CMD_SRQ_ENABLE_W: begin
                    sre_q <= CMD_DATA[7:0] & ~(8'h01 << `BSR_SB_MSS); // RULE_09 RULE_20
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Summaries and status byte, combinational from latched events, error count and output queue input
    assign hsb = |(hw_ev_q & hw_en_q); // RULE_14 RULE_23
    assign csb = |(coupl_ev_q & coupl_en_q);
    assign ssb = |(instr_ev_q & instr_en_q);
    assign esb = |(std_ev_q & std_en_q); // RULE_06
    assign erb = err_cnt_q != '0; // RULE_07
    assign sb_core = {erb, 1'b0, esb, OUTQ_NOT_EMPTY, // RULE_01 RULE_05
                      hsb, csb, ssb, 1'b0}; // RULE_08
    assign reason = sb_core & sre_q;
    assign mss = |reason; // RULE_02
    assign STATUS_BYTE = sb_core | (8'(mss) << `BSR_SB_MSS);
    assign SRQ = rqs_q;

    // Request flag: new enabled reason sets; no reason or poll clears
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            reason_prev_q <= `BSR_RST8;
            rqs_q <= 1'b0;
        end else begin
            reason_prev_q <= reason;
            if (|(reason & ~reason_prev_q)) begin
                rqs_q <= 1'b1; // RULE_21
            end else if (!mss || POLL_STROBE) begin
                rqs_q <= 1'b0; // RULE_21 RULE_04
            end
        end
    end

    // Serial poll answer
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            POLL_VALID <= 1'b0;
            POLL_DATA <= `BSR_RST8;
        end else begin
            POLL_VALID <= POLL_STROBE;
            if (POLL_STROBE) begin
                POLL_DATA <= sb_core | (8'(rqs_q) << `BSR_SB_MSS); // RULE_04
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error queue: full drops new entries, clear empties it
    assign err_full = err_cnt_q == (PW+1)'(ERRQ_DEPTH);
    assign ERR_QUEUE_FULL = err_full;
    assign err_pop = is_cmd(CMD_VALID, CMD_CODE, bsr_pkg::BSR_CMD_ERROR_Q) && erb;
    assign err_push_ok = ERR_PUSH && (!err_full || err_pop) && !do_cls;

    // Write port of the queue storage
    always_ff @(posedge CORE_CLK) begin
        if (err_push_ok) begin
            errq_mem[wr_ptr_q] <= ERR_CODE;
        end
    end

    // Read and write pointers, fill count
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            err_cnt_q <= '0;
        end else if (do_cls) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            err_cnt_q <= '0;
        end else begin
            if (err_push_ok) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (err_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            err_cnt_q <= err_cnt_q + (PW+1)'(err_push_ok) - (PW+1)'(err_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query answers, registered one cycle after the command
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESP_VALID <= 1'b0;
            RESP_DATA <= `BSR_RST16;
        end else begin
            RESP_VALID <= 1'b0;
            if (CMD_VALID) begin
                RESP_VALID <= 1'b1;
                unique case (CMD_CODE)
                    bsr_pkg::BSR_CMD_STATUS_BYTE_Q: begin
                        RESP_DATA <= {8'h00, STATUS_BYTE}; // RULE_03 RULE_22
                    end
                    bsr_pkg::BSR_CMD_SRQ_ENABLE_Q: RESP_DATA <= {8'h00, sre_q}; // RULE_09 RULE_20
                    bsr_pkg::BSR_CMD_STD_ENABLE_Q: RESP_DATA <= {8'h00, std_en_q};
                    bsr_pkg::BSR_CMD_STD_EVENT_Q: RESP_DATA <= {8'h00, std_ev_q};
                    bsr_pkg::BSR_CMD_HW_COND_Q: RESP_DATA <= hw_live; // RULE_10
                    bsr_pkg::BSR_CMD_HW_ENABLE_Q: RESP_DATA <= hw_en_q; // RULE_14
                    bsr_pkg::BSR_CMD_HW_EVENT_Q: RESP_DATA <= hw_ev_q; // RULE_17
                    bsr_pkg::BSR_CMD_COUPL_COND_Q: RESP_DATA <= coupl_live;
                    bsr_pkg::BSR_CMD_COUPL_ENABLE_Q: RESP_DATA <= coupl_en_q;
                    bsr_pkg::BSR_CMD_COUPL_EVENT_Q: RESP_DATA <= coupl_ev_q;
                    bsr_pkg::BSR_CMD_INSTR_COND_Q: RESP_DATA <= {8'h00, instr_live};
                    bsr_pkg::BSR_CMD_INSTR_ENABLE_Q: RESP_DATA <= {8'h00, instr_en_q};
                    bsr_pkg::BSR_CMD_INSTR_EVENT_Q: RESP_DATA <= {8'h00, instr_ev_q}; // RULE_18
                    bsr_pkg::BSR_CMD_ERROR_Q: begin
                        if (!erb) begin
                            RESP_DATA <= {8'h00, `BSR_ERR_EMPTY}; // RULE_19
                        end else if (err_full) begin
                            RESP_DATA <= {8'h00, `BSR_ERR_FULL}; // RULE_19
                        end else begin
                            RESP_DATA <= {8'h00, errq_mem[rd_ptr_q]}; // RULE_19
                        end
                    end
                    default: begin
                        RESP_VALID <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// file: bsr_defines.svh
// Purpose: Constants of the bus status reporting unit
// Assumes: Included by bare name
// Notes: Bit positions, reset values, filter senses
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

// Status byte bit positions
`define BSR_SB_INSTR 1
`define BSR_SB_COUPL 2
`define BSR_SB_HW 3
`define BSR_SB_MAV 4
`define BSR_SB_ESB 5
`define BSR_SB_MSS 6
`define BSR_SB_ERB 7

// Reset values
`define BSR_RST8 8'h00
`define BSR_RST16 16'h0000

// Implemented bits of the device structures
`define BSR_HW_USED 16'hC0FF
`define BSR_INSTR_USED 8'h0F

// Transition sense: 1 = rising edge sets event, 0 = falling edge
`define BSR_HW_RISE 16'hFFFF
`define BSR_INSTR_RISE 8'h00
`define BSR_COUPL_RISE 16'hFFFF

// Error query answers
`define BSR_ERR_EMPTY 8'h00
`define BSR_ERR_FULL 8'hFF

// Error queue depth default
`define BSR_ERRQ_DEPTH 8

`endif

// file: bsr_pkg.sv
// Purpose: Types of the bus status reporting unit
// Assumes: Codes follow declaration order
// Notes: Command codes are driven on CMD_CODE
package bsr_pkg;
    typedef enum logic [4:0] {
        BSR_CMD_CLEAR_STATUS,
        BSR_CMD_STATUS_BYTE_Q,
        BSR_CMD_SRQ_ENABLE_W,
        BSR_CMD_SRQ_ENABLE_Q,
        BSR_CMD_STD_ENABLE_W,
        BSR_CMD_STD_ENABLE_Q,
        BSR_CMD_STD_EVENT_Q,
        BSR_CMD_HW_COND_Q,
        BSR_CMD_HW_ENABLE_W,
        BSR_CMD_HW_ENABLE_Q,
        BSR_CMD_HW_EVENT_Q,
        BSR_CMD_COUPL_COND_Q,
        BSR_CMD_COUPL_ENABLE_W,
        BSR_CMD_COUPL_ENABLE_Q,
        BSR_CMD_COUPL_EVENT_Q,
        BSR_CMD_INSTR_COND_Q,
        BSR_CMD_INSTR_ENABLE_W,
        BSR_CMD_INSTR_ENABLE_Q,
        BSR_CMD_INSTR_EVENT_Q,
        BSR_CMD_ERROR_Q
    } bsr_cmd_t;
endpackage

// file: bsr_status_unit_sva.sv
// Purpose: Port-level checks of the status reporting unit
// Assumes: Command codes in enum order, answers one cycle late
// Notes: Bound into every bsr_status_unit instance
`timescale 1ns/100ps
module bsr_status_unit_sva #(
    parameter int COUPL_W = 16
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CMD_VALID,
    input wire logic [4:0] CMD_CODE,
    input wire logic RESP_VALID,
    input wire logic [15:0] RESP_DATA,
    input wire logic POLL_STROBE,
    input wire logic POLL_VALID,
    input wire logic [7:0] POLL_DATA,
    input wire logic SRQ,
    input wire logic [7:0] STATUS_BYTE,
    input wire logic OUTQ_NOT_EMPTY,
    input wire logic [15:0] HW_COND,
    input wire logic ERR_QUEUE_FULL
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    logic is_q;
    // Query codes are the ones that give an answer
    assign is_q = CMD_VALID && (CMD_CODE inside {5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09,
        5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13});
    // Poll answer carries the request flag of the poll cycle
    sequence poll_answer;
        POLL_VALID && (POLL_DATA[6] == $past(SRQ));
    endsequence
    //////////////////////////////////////////////////////////////////////
    bit0_zero_a: assert property (STATUS_BYTE[0] == 1'b0)
        else $error("status bit 0 not zero");
    mav_track_a: assert property (STATUS_BYTE[4] == OUTQ_NOT_EMPTY)
        else $error("message available bit wrong");
    answer_pulse_a: assert property (RESP_VALID == $past(is_q))
        else $error("answer strobe wrong");
    stb_answer_a: assert property (CMD_VALID && CMD_CODE == 5'h01
        |=> RESP_DATA == {8'h00, $past(STATUS_BYTE)}) else $error("status query answer wrong");
    sre_read_a: assert property (CMD_VALID && CMD_CODE == 5'h03
        |=> RESP_DATA[15:8] == 8'h00 && RESP_DATA[6] == 1'b0)
        else $error("service enable bit 6 not zero");
    hw_cond_a: assert property (CMD_VALID && CMD_CODE == 5'h07 && $stable(HW_COND)
        |=> RESP_DATA == ($past(HW_COND) & 16'hC0FF)) else $error("hardware condition wrong");
    poll_ans_a: assert property (POLL_STROBE |=> poll_answer)
        else $error("poll answer wrong");
    srq_rise_a: assert property ($rose(SRQ) |-> $past(STATUS_BYTE[6]))
        else $error("request flag rose without summary");
    mss_low_a: assert property (!STATUS_BYTE[6] |=> !SRQ)
        else $error("request flag held without summary");
    err_full_a: assert property (ERR_QUEUE_FULL |-> STATUS_BYTE[7])
        else $error("error summary low with full queue");
endmodule
//////////////////////////////////////////////////////////////////////////
bind bsr_status_unit bsr_status_unit_sva #(.COUPL_W(COUPL_W)) i_bsr_status_unit_sva (
    .CORE_CLK, .RESET_N, .CMD_VALID, .CMD_CODE, .RESP_VALID, .RESP_DATA, .POLL_STROBE,
    .POLL_VALID, .POLL_DATA, .SRQ, .STATUS_BYTE, .OUTQ_NOT_EMPTY, .HW_COND, .ERR_QUEUE_FULL);

// file: bsr_ctrl_model.sv
// Purpose: Bus controller issuing commands and serial polls
// Assumes: Answers arrive one cycle after the command edge
// Notes: Data lines show inverted value once released
`timescale 1ns/100ps
module bsr_ctrl_model (
    input wire logic CORE_CLK,
    output logic CMD_VALID,
    output logic [4:0] CMD_CODE,
    output logic [15:0] CMD_DATA,
    output logic POLL_STROBE,
    input wire logic RESP_VALID,
    input wire logic [15:0] RESP_DATA,
    input wire logic POLL_VALID,
    input wire logic [7:0] POLL_DATA
);
    logic got;
    logic pgot;
    logic [15:0] rdata;
    logic [7:0] pdata;
    // Idle bus at time zero
    initial begin
        CMD_VALID = 1'b0;
        CMD_CODE = 5'h00;
        CMD_DATA = 16'h0000;
        POLL_STROBE = 1'b0;
    end
    // Write or query an enable or status register
    task automatic cmd(input bsr_pkg::bsr_cmd_t c, input logic [15:0] d);
        @(posedge CORE_CLK);
        #1;
        CMD_VALID = 1'b1;
        CMD_CODE = c;
        CMD_DATA = d;
        @(posedge CORE_CLK);
        #1;
        got = RESP_VALID;
        rdata = RESP_DATA;
        CMD_VALID = 1'b0;
        CMD_DATA = ~d; // Released bus carries no stale value
    endtask
    // Serial poll, answer taken one cycle later
    task automatic poll();
        @(posedge CORE_CLK);
        #1;
        POLL_STROBE = 1'b1;
        @(posedge CORE_CLK);
        #1;
        pgot = POLL_VALID;
        pdata = POLL_DATA;
        POLL_STROBE = 1'b0;
    endtask
endmodule

// file: tb_bsr_status_unit.sv
// Purpose: Self-checking bench of the status reporting unit
// Assumes: Queue depth 8, coupling width 16
// Notes: Commands go through the controller model
`timescale 1ns/100ps
`define CHK(a, e) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); \
    end \
end
module tb_bsr_status_unit;
    logic CORE_CLK, RESET_N, CMD_VALID, RESP_VALID, POLL_STROBE, POLL_VALID, SRQ;
    logic OUTQ_NOT_EMPTY, ERR_PUSH, ERR_QUEUE_FULL;
    logic [4:0] CMD_CODE;
    logic [15:0] CMD_DATA, RESP_DATA, HW_COND, COUPL_COND;
    logic [7:0] POLL_DATA, STATUS_BYTE, STD_EVENT_SET, INSTR_COND, ERR_CODE;
    int n_mismatch;
    int tests_run;
    bsr_status_unit #(.COUPL_W(16), .ERRQ_DEPTH(8)) i_bsr_status_unit (.CORE_CLK, .RESET_N,
        .CMD_VALID, .CMD_CODE, .CMD_DATA, .RESP_VALID, .RESP_DATA, .POLL_STROBE, .POLL_VALID,
        .POLL_DATA, .SRQ, .STATUS_BYTE, .OUTQ_NOT_EMPTY, .STD_EVENT_SET, .HW_COND,
        .COUPL_COND, .INSTR_COND, .ERR_PUSH, .ERR_CODE, .ERR_QUEUE_FULL);
    bsr_ctrl_model i_bsr_ctrl_model (.CORE_CLK, .CMD_VALID, .CMD_CODE, .CMD_DATA,
        .POLL_STROBE, .RESP_VALID, .RESP_DATA, .POLL_VALID, .POLL_DATA);
    //////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge CORE_CLK);
        #1;
    endtask
    // Query with expected answer
    task automatic q(input bsr_pkg::bsr_cmd_t c, input logic [15:0] e);
        i_bsr_ctrl_model.cmd(c, 16'h0000);
        `CHK(i_bsr_ctrl_model.got, 1'b1)
        `CHK(i_bsr_ctrl_model.rdata, e)
    endtask
    // Bounded wait for status and request bits
    task automatic wait9(input logic [8:0] m);
        int i;
        for (i = 0; i < 6 && (({SRQ, STATUS_BYTE} & m) !== m); i++) tick();
        `CHK({SRQ, STATUS_BYTE} & m, m)
        if (({SRQ, STATUS_BYTE} & m) !== m) report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Clock of 100 ns period
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    // Main sequence
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        RESET_N = 1'b0;
        OUTQ_NOT_EMPTY = 1'b0;
        STD_EVENT_SET = 8'h00;
        HW_COND = 16'h0000;
        COUPL_COND = 16'h0000;
        INSTR_COND = 8'h00;
        ERR_PUSH = 1'b0;
        ERR_CODE = 8'h00;
        repeat (8) tick();
        RESET_N = 1'b1;
        `CHK(STATUS_BYTE, 8'h00);
        OUTQ_NOT_EMPTY = 1'b1;
        tick();
        `CHK(STATUS_BYTE, 8'h10);
        OUTQ_NOT_EMPTY = 1'b0;
        q(bsr_pkg::BSR_CMD_SRQ_ENABLE_Q, 16'h0000);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_SRQ_ENABLE_W, 16'h00FF);
        `CHK(i_bsr_ctrl_model.got, 1'b0);
        q(bsr_pkg::BSR_CMD_SRQ_ENABLE_Q, 16'h00BF);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_HW_ENABLE_W, 16'hFFFF);
        q(bsr_pkg::BSR_CMD_HW_ENABLE_Q, 16'hFFFF);
        $display("test enables done");
        HW_COND = 16'hC281;
        wait9(9'h148);
        `CHK(STATUS_BYTE, 8'h48);
        q(bsr_pkg::BSR_CMD_STATUS_BYTE_Q, 16'h0048);
        q(bsr_pkg::BSR_CMD_STATUS_BYTE_Q, 16'h0048);
        i_bsr_ctrl_model.poll();
        `CHK(i_bsr_ctrl_model.pgot, 1'b1);
        `CHK(i_bsr_ctrl_model.pdata, 8'h48);
        `CHK(SRQ, 1'b0);
        i_bsr_ctrl_model.poll();
        `CHK(i_bsr_ctrl_model.pdata, 8'h08);
        `CHK(STATUS_BYTE, 8'h48);
        q(bsr_pkg::BSR_CMD_HW_COND_Q, 16'hC081);
        q(bsr_pkg::BSR_CMD_HW_EVENT_Q, 16'hC081);
        q(bsr_pkg::BSR_CMD_HW_EVENT_Q, 16'h0000);
        `CHK(STATUS_BYTE, 8'h00);
        HW_COND = 16'h0000;
        repeat (2) tick();
        HW_COND = 16'h0001;
        wait9(9'h008);
        HW_COND = 16'h0000;
        repeat (3) tick();
        `CHK(STATUS_BYTE[3], 1'b1);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_CLEAR_STATUS, 16'h0000);
        `CHK(STATUS_BYTE[3], 1'b0);
        q(bsr_pkg::BSR_CMD_HW_ENABLE_Q, 16'hFFFF);
        $display("test hardware events done");
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_INSTR_ENABLE_W, 16'h0001);
        INSTR_COND = 8'hFF;
        repeat (3) tick();
        `CHK(STATUS_BYTE[1], 1'b0);
        INSTR_COND = 8'h00;
        wait9(9'h002);
        q(bsr_pkg::BSR_CMD_INSTR_EVENT_Q, 16'h000F);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_COUPL_ENABLE_W, 16'h0008);
        COUPL_COND = 16'h0008;
        wait9(9'h004);
        q(bsr_pkg::BSR_CMD_COUPL_EVENT_Q, 16'h0008);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_STD_ENABLE_W, 16'h0001);
        STD_EVENT_SET = 8'h01;
        tick();
        STD_EVENT_SET = 8'h00;
        wait9(9'h020);
        q(bsr_pkg::BSR_CMD_STD_EVENT_Q, 16'h0001);
        $display("test structures done");
        for (int i = 0; i < 10; i++) begin
            ERR_PUSH = (i != 3);
            ERR_CODE = 8'h20 + 8'(i);
            tick();
            if (i == 2) begin
                ERR_PUSH = 1'b0;
                wait9(9'h080);
                q(bsr_pkg::BSR_CMD_ERROR_Q, 16'h0020);
            end
        end
        ERR_PUSH = 1'b0;
        `CHK(ERR_QUEUE_FULL, 1'b1);
        q(bsr_pkg::BSR_CMD_ERROR_Q, 16'h00FF);
        i_bsr_ctrl_model.cmd(bsr_pkg::BSR_CMD_CLEAR_STATUS, 16'h0000);
        q(bsr_pkg::BSR_CMD_ERROR_Q, 16'h0000);
        `CHK(STATUS_BYTE[7], 1'b0);
        $display("test error queue done");
        report_and_stop();
    end
endmodule
